/* src/swmon_defs.svh */
`ifndef SWMON_DEFS_SVH
`define SWMON_DEFS_SVH

// ==========================================================
// Serial word layout
`define WORD_BITS 24
`define BIT_CNT_W 5
`define ST_INT_BIT 23
`define ST_THERM_BIT 22
`define ST_SP_LSB 14
`define ST_SG_LSB 0
`define SP_COUNT 8
`define SG_COUNT 14
`define SW_COUNT 22

// ==========================================================
// Timing
`define CLK_KHZ 40000
`define WET_PULSE_MS 16
`define WET_PULSE_CYC (`WET_PULSE_MS * `CLK_KHZ)
`define SCAN_US 200
`define SCAN_CYC ((`SCAN_US * `CLK_KHZ) / 1000)
`define SCAN_PERIOD_US 10000
`define SCAN_PERIOD_CYC ((`SCAN_PERIOD_US * `CLK_KHZ) / 1000)
`define TMR_W 20

`endif

/* src/swmon_pkg.sv */
package swmon_pkg;

    // ======================================================
    // Operating mode
    typedef enum logic [0:0] {
        MODE_NORMAL = 1'b0, // Awake, SPI programmable
        MODE_SLEEP = 1'b1 // Low power, periodic scan
    } mode_t;

endpackage

/* src/spi_link_if.sv */
`timescale 1ns/1ps
`include "swmon_defs.svh"

// ==========================================================
// Events and data between edge logic and shift register
interface spi_link_if;
    logic cs_fall; // Chip select fell, synced pulse
    logic cs_rise; // Chip select rose, synced pulse
    logic sclk_rise; // Serial clock rose, synced pulse
    logic sclk_fall; // Serial clock fell, synced pulse
    logic si_bit; // Synced serial input
    logic [`WORD_BITS-1:0] load_word; // Status to capture
    logic so_bit; // Serial output data
    logic so_oe; // Serial output driver enable
    logic [`WORD_BITS-1:0] rx_word; // Shifted-in command
    logic [`BIT_CNT_W-1:0] bit_cnt; // Bits shifted this frame

    modport ctl (
        output cs_fall, cs_rise, sclk_rise, sclk_fall, si_bit,
        output load_word,
        input so_bit, so_oe, rx_word, bit_cnt
    );
    modport shf (
        input cs_fall, cs_rise, sclk_rise, sclk_fall, si_bit,
        input load_word,
        output so_bit, so_oe, rx_word, bit_cnt
    );
endinterface

/* src/spi_word_shifter.sv */
`timescale 1ns/1ps
`include "swmon_defs.svh"

// ==========================================================
// Shared 24-bit shift register: status out, command in
module spi_word_shifter
    import swmon_pkg::*;
(
    input wire logic clk, // System clock
    input wire logic nrst, // Async reset, active low
    spi_link_if.shf lnk // Edge events and data
);

    // ======================================================
    // State
    logic [`WORD_BITS-1:0] shift_r, shift_nxt; // Shift register
    logic so_r, so_nxt; // Output bit
    logic oe_r, oe_nxt; // Output enable, also frame active
    logic [`BIT_CNT_W-1:0] cnt_r, cnt_nxt; // Received bits

    // Next-state logic
    always_comb begin
        shift_nxt = shift_r;
        so_nxt = so_r;
        oe_nxt = oe_r;
        cnt_nxt = cnt_r;
        if (lnk.cs_fall) begin
            // Capture status, open the driver
            shift_nxt = lnk.load_word;
            oe_nxt = 1'b1;
            cnt_nxt = '0;
        end else if (lnk.cs_rise) begin
            // Release the driver
            oe_nxt = 1'b0;
        end else if (oe_r) begin
            // Frame active: clock edges act
            if (lnk.sclk_rise) begin
                so_nxt = shift_r[`WORD_BITS-1];
            end
            if (lnk.sclk_fall) begin
                shift_nxt = {shift_r[`WORD_BITS-2:0], lnk.si_bit};
                if (cnt_r != '1) begin
                    cnt_nxt = cnt_r + 1'b1;
                end
            end
        end
        // Frame idle: clock and data ignored
    end

    // Registers
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            shift_r <= '0;
            so_r <= 1'b0;
            oe_r <= 1'b0;
            cnt_r <= '0;
        end else begin
            shift_r <= shift_nxt;
            so_r <= so_nxt;
            oe_r <= oe_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    assign lnk.so_bit = so_r;
    assign lnk.so_oe = oe_r;
    assign lnk.rx_word = shift_r;
    assign lnk.bit_cnt = cnt_r;

endmodule

/* src/switch_monitor_spi_wake_port.sv */
// Behaviour
// - CS fall: enable SO, capture switches, alert
// - CS rise: SO back to high impedance
// - CS rise clears alert unless new change
// - Command applied only at CS rise
// - CS fall wakes sleep if logic supply present; data maybe invalid
// - SI sampled on SCLK falling edge
// - SO advances on SCLK rise, sampled falling
// - CS high: ignore SCLK, SI; SO tri-stated
// - Open switch reads zero, closed one
// - First SCLK rise presents bit 24
// - Both words MSB first, one register
// - Normal mode: enabled change asserts alert
// - Interrupt bit captured at CS fall
// - Only detecting device reports interrupt bit
// - Sleep, wake high, logic supply present: alert fall wakes
// - Power enable low normal, high sleep
// - Power enable fall wakes, alert gated
// - Wetting pulse lasts 16 ms
// - Sleep scans switches, 200 us window
// - Every response carries switches, flags
`timescale 1ns/1ps
`include "swmon_defs.svh"

module switch_monitor_spi_wake_port
    import swmon_pkg::*;
#(
    parameter logic [`TMR_W-1:0] WET_CYC = `TMR_W'(`WET_PULSE_CYC),
    parameter logic [`TMR_W-1:0] SCAN_CYC = `TMR_W'(`SCAN_CYC),
    parameter logic [`TMR_W-1:0] SCAN_PERIOD =
        `TMR_W'(`SCAN_PERIOD_CYC)
) (
    input wire logic clk, // System clock, 40 MHz
    input wire logic nrst, // Power-on reset, active low
    input wire logic cs_n, // Chip select pin
    input wire logic sclk, // Serial clock pin
    input wire logic si, // Serial data in pin
    output logic so_o, // Serial data out
    output logic so_oe, // Serial out driver enable
    input wire logic int_n_i, // Alert line level
    output logic int_n_o, // Alert drive value, always low
    output logic int_n_oe, // Alert pull-down enable
    input wire logic wake_n_i, // Power enable line level
    output logic wake_n_o, // Power enable drive, always low
    output logic wake_n_oe, // Power enable pull-down enable
    input wire logic vdd_present, // Logic supply present
    input wire logic thermal_flag, // Over-temperature flag
    input wire logic [`SP_COUNT-1:0] programmable_switch_inputs, // Comp.
    input wire logic [`SG_COUNT-1:0] ground_switch_inputs, // Comparators
    input wire logic [`SP_COUNT-1:0] sp_battery_sel, // 1: to battery
    input wire logic [`SW_COUNT-1:0] int_enable, // Change alert enables
    input wire logic sleep_req, // Enter sleep, pulse
    output logic [`WORD_BITS-1:0] cmd_word, // Applied command
    output logic cmd_valid, // New command, pulse
    output logic sleep_mode, // Device is asleep
    output logic wetting_on, // Wetting pulse active
    output logic scan_active, // Sleep scan window
    output logic wake_xfer_suspect // Frame began by a wake
);

    // ======================================================
    // Pin synchronisers
    localparam int PIN_W = `SW_COUNT + 6; // Pins to sync
    localparam int P_CS = `SW_COUNT; // Bit positions in vector
    localparam int P_SCLK = `SW_COUNT + 1;
    localparam int P_SI = `SW_COUNT + 2;
    localparam int P_INT = `SW_COUNT + 3;
    localparam int P_WAKE = `SW_COUNT + 4;
    localparam int P_VDD = `SW_COUNT + 5;

    logic [PIN_W-1:0] pins; // Raw pin vector
    logic [PIN_W-1:0] meta_r, meta_nxt; // First stage
    logic [PIN_W-1:0] sync_r, sync_nxt; // Second stage
    logic [PIN_W-1:0] last_r, last_nxt; // Edge history
    logic therm_meta_r, therm_sync_r; // Thermal flag chain
    logic therm_meta_nxt, therm_sync_nxt;

    assign pins = {vdd_present, wake_n_i, int_n_i, si, sclk, cs_n,
        programmable_switch_inputs, ground_switch_inputs};

    // Two-flop chain, then an edge history stage
    always_comb begin
        meta_nxt = pins;
        sync_nxt = meta_r;
        last_nxt = sync_r;
        therm_meta_nxt = thermal_flag;
        therm_sync_nxt = therm_meta_r;
    end

    // Synchroniser registers; idle levels at reset
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            meta_r <= {6'h39, `SW_COUNT'h0};
            sync_r <= {6'h39, `SW_COUNT'h0};
            last_r <= {6'h39, `SW_COUNT'h0};
            therm_meta_r <= 1'b0;
            therm_sync_r <= 1'b0;
        end else begin
            meta_r <= meta_nxt;
            sync_r <= sync_nxt;
            last_r <= last_nxt;
            therm_meta_r <= therm_meta_nxt;
            therm_sync_r <= therm_sync_nxt;
        end
    end

    // ======================================================
    // Edge events and switch decoding
    logic cs_fall, cs_rise, sclk_rise, sclk_fall; // Link events
    logic int_fall, wake_fall; // Shared line falls
    logic vdd_s, int_s, wake_s; // Synced levels
    logic [`SP_COUNT-1:0] sp_s; // Synced programmable inputs
    logic [`SG_COUNT-1:0] sg_s; // Synced ground inputs
    logic [`SW_COUNT-1:0] closed; // 1 = switch closed

    assign cs_fall = last_r[P_CS] & ~sync_r[P_CS];
    assign cs_rise = ~last_r[P_CS] & sync_r[P_CS];
    assign sclk_rise = ~last_r[P_SCLK] & sync_r[P_SCLK];
    assign sclk_fall = last_r[P_SCLK] & ~sync_r[P_SCLK];
    assign int_fall = last_r[P_INT] & ~sync_r[P_INT];
    assign wake_fall = last_r[P_WAKE] & ~sync_r[P_WAKE];
    assign vdd_s = sync_r[P_VDD];
    assign int_s = sync_r[P_INT];
    assign wake_s = sync_r[P_WAKE];
    assign sp_s = sync_r[`SW_COUNT-1:`SG_COUNT];
    assign sg_s = sync_r[`SG_COUNT-1:0];

    // Battery inputs close high, ground inputs close low
    genvar gi;
    generate
        for (gi = 0; gi < `SP_COUNT; gi++) begin : g_sp
            assign closed[`SG_COUNT+gi] = sp_battery_sel[gi] ?
                sp_s[gi] : ~sp_s[gi];
        end
    endgenerate
    assign closed[`SG_COUNT-1:0] = ~sg_s;

    // ======================================================
    // Shift register link
    spi_link_if lnk ();

    logic alert_r, alert_nxt; // Own alert, also interrupt bit

    assign lnk.cs_fall = cs_fall;
    assign lnk.cs_rise = cs_rise;
    assign lnk.sclk_rise = sclk_rise;
    assign lnk.sclk_fall = sclk_fall;
    assign lnk.si_bit = sync_r[P_SI];
    // Status word: own alert, thermal, switch states
    assign lnk.load_word = {alert_r, therm_sync_r, closed};

    spi_word_shifter u_shifter (
        .clk (clk),
        .nrst (nrst),
        .lnk (lnk)
    );

    // ======================================================
    // Mode, alert and command state
    mode_t mode_r, mode_nxt; // Operating mode
    logic [`SW_COUNT-1:0] prev_r, prev_nxt; // Last seen switches
    logic chg_cs_r, chg_cs_nxt; // Change while CS low
    logic [`WORD_BITS-1:0] cmd_r, cmd_nxt; // Applied command
    logic cmd_v_r, cmd_v_nxt; // Command pulse
    logic suspect_r, suspect_nxt; // Wake frame marker
    logic change; // Enabled change, normal mode
    logic scan_change; // Change seen at scan end
    logic scan_end; // Last cycle of scan period
    logic wake_evt; // Any wake source

    assign change = (mode_r == MODE_NORMAL) &&
        ((closed ^ prev_r) & int_enable) != '0;
    assign scan_change = ((closed ^ prev_r) & int_enable) != '0;

    // Wake sources while asleep
    always_comb begin
        wake_evt = 1'b0;
        if (mode_r == MODE_SLEEP) begin
            if (cs_fall && vdd_s) begin
                wake_evt = 1'b1;
            end
            if (int_fall && wake_s && vdd_s) begin
                wake_evt = 1'b1;
            end
            if (wake_fall && (!vdd_s || int_s)) begin
                wake_evt = 1'b1;
            end
            if (scan_end && scan_change) begin
                wake_evt = 1'b1;
            end
        end
    end

    // Next mode, alert, command state
    always_comb begin
        mode_nxt = mode_r;
        prev_nxt = prev_r;
        alert_nxt = alert_r;
        chg_cs_nxt = chg_cs_r;
        cmd_nxt = cmd_r;
        cmd_v_nxt = 1'b0;
        suspect_nxt = suspect_r;
        unique case (mode_r)
            MODE_NORMAL: begin
                // Track switches continuously
                prev_nxt = closed;
                if (sleep_req) begin
                    mode_nxt = MODE_SLEEP;
                end
            end
            MODE_SLEEP: begin
                // Compare only at end of each scan
                if (scan_end) begin
                    prev_nxt = closed;
                end
                if (wake_evt) begin
                    mode_nxt = MODE_NORMAL;
                    prev_nxt = closed;
                end
            end
        endcase
        // Change flag during frame; new frame restarts it
        if (cs_fall) begin
            chg_cs_nxt = 1'b0;
        end
        if (change && sync_r[P_CS] == 1'b0) begin
            chg_cs_nxt = 1'b1;
        end
        // Alert clears at CS rise unless changed in frame
        if (cs_rise && !chg_cs_r) begin
            alert_nxt = 1'b0;
        end
        if (change) begin
            alert_nxt = 1'b1;
        end
        // Complete word becomes the command at CS rise
        if (cs_rise && lnk.bit_cnt == `BIT_CNT_W'(`WORD_BITS)) begin
            cmd_nxt = lnk.rx_word;
            cmd_v_nxt = 1'b1;
        end
        // Frame opened by a wake may carry stale status
        if (cs_fall) begin
            suspect_nxt = (mode_r == MODE_SLEEP) && vdd_s;
        end
    end

    // Mode and alert registers; reset lands in normal mode
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            mode_r <= MODE_NORMAL;
            prev_r <= '0;
            alert_r <= 1'b0;
            chg_cs_r <= 1'b0;
            cmd_r <= '0;
            cmd_v_r <= 1'b0;
            suspect_r <= 1'b0;
        end else begin
            mode_r <= mode_nxt;
            prev_r <= prev_nxt;
            alert_r <= alert_nxt;
            chg_cs_r <= chg_cs_nxt;
            cmd_r <= cmd_nxt;
            cmd_v_r <= cmd_v_nxt;
            suspect_r <= suspect_nxt;
        end
    end

    // ======================================================
    // Wetting pulse and sleep scan timers
    logic [`TMR_W-1:0] wet_r, wet_nxt; // Wetting time left
    logic [`TMR_W-1:0] per_r, per_nxt; // Scan period countdown

    assign scan_end = (mode_r == MODE_SLEEP) && per_r == '0;

    // Timer next values
    always_comb begin
        wet_nxt = wet_r;
        per_nxt = per_r;
        if (mode_r == MODE_SLEEP) begin
            // Wetting off asleep; period runs
            wet_nxt = '0;
            if (wake_evt) begin
                wet_nxt = WET_CYC;
            end
            per_nxt = (per_r == '0) ? SCAN_PERIOD - 1'b1 :
                per_r - 1'b1;
        end else begin
            // Pulse counts down once after wake
            if (wet_r != '0) begin
                wet_nxt = wet_r - 1'b1;
            end
            per_nxt = SCAN_PERIOD - 1'b1;
        end
    end

    // Timer registers; pulse runs from power-on
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            wet_r <= WET_CYC;
            per_r <= SCAN_PERIOD - 1'b1;
        end else begin
            wet_r <= wet_nxt;
            per_r <= per_nxt;
        end
    end

    // ======================================================
    // Outputs
    assign so_o = lnk.so_bit;
    assign so_oe = lnk.so_oe;
    assign int_n_o = 1'b0;
    assign int_n_oe = alert_r;
    assign wake_n_o = 1'b0;
    assign wake_n_oe = (mode_r == MODE_NORMAL);
    assign cmd_word = cmd_r;
    assign cmd_valid = cmd_v_r;
    assign sleep_mode = (mode_r == MODE_SLEEP);
    assign wetting_on = (wet_r != '0);
    assign scan_active = (mode_r == MODE_SLEEP) && per_r < SCAN_CYC;
    assign wake_xfer_suspect = suspect_r;

endmodule

/* test/swmon_port_chk_sva.sv */
`timescale 1ns/1ps
`include "swmon_defs.svh"

// ==========================================================
// Port checker for the switch monitor serial port
module swmon_port_chk
    import swmon_pkg::*;
(
    input wire logic clk, // System clock
    input wire logic nrst, // Async reset, active low
    input wire logic cs_n, // Chip select pin
    input wire logic sclk, // Serial clock pin
    input wire logic so_o, // Serial data out
    input wire logic so_oe, // Serial out enable
    input wire logic int_n_oe, // Alert pull-down enable
    input wire logic wake_n_oe, // Power enable pull-down
    input wire logic sleep_req, // Sleep request pulse
    input wire logic [`WORD_BITS-1:0] cmd_word, // Applied command
    input wire logic cmd_valid, // Command pulse
    input wire logic sleep_mode, // Asleep
    input wire logic scan_active // Sleep scan window
);
    // ======================================================
    // Properties, one clock domain
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);

    a_oe_on: assert property (
        $fell(cs_n) |-> ##[2:5] so_oe)
        else $error("SO driver not enabled after select");
    a_oe_off: assert property (
        $rose(cs_n) |-> ##[2:5] !so_oe)
        else $error("SO driver not released after deselect");
    a_oe_idle: assert property (
        cs_n [*6] |-> !so_oe)
        else $error("SO driven while deselected");
    a_cmd_at_rise: assert property (
        cmd_valid |-> cs_n && $past(cs_n, 2))
        else $error("Command applied outside deselect");
    a_cmd_word_hold: assert property (
        $changed(cmd_word) |-> cmd_valid)
        else $error("Command word changed without pulse");
    a_cmd_one_pulse: assert property (
        cmd_valid |=> !cmd_valid)
        else $error("Command pulse longer than one cycle");
    a_alert_clear: assert property (
        $fell(int_n_oe) |-> cs_n && $past(cs_n, 2))
        else $error("Alert cleared away from deselect");
    a_so_step: assert property (
        $changed(so_o) |-> $past(sclk, 2))
        else $error("SO moved without a serial clock rise");
    a_wake_level: assert property (
        $fell(wake_n_oe) |-> sleep_mode && $past(sleep_req))
        else $error("Power enable released without a sleep request");
    a_sleep_go: assert property (
        sleep_req && !sleep_mode |=> sleep_mode)
        else $error("Sleep request not taken");
    a_scan_sleep: assert property (
        scan_active |-> sleep_mode && $past(sleep_mode, 8))
        else $error("Scan window outside sleep");
endmodule

bind switch_monitor_spi_wake_port swmon_port_chk u_chk (
    .clk(clk), .nrst(nrst), .cs_n(cs_n), .sclk(sclk), .so_o(so_o),
    .so_oe(so_oe), .int_n_oe(int_n_oe), .wake_n_oe(wake_n_oe),
    .sleep_req(sleep_req), .cmd_word(cmd_word), .cmd_valid(cmd_valid),
    .sleep_mode(sleep_mode), .scan_active(scan_active)
);

/* test/spi_master_model.sv */
`timescale 1ns/1ps

// ==========================================================
// Host controller acting as serial master
module spi_master_model (
    input wire logic clk, // System clock
    input wire logic so_o, // Serial data from device
    output logic cs_n, // Chip select, active low
    output logic sclk, // Serial clock, idles low
    output logic si // Serial data to device
);
    // Idle levels at time zero
    initial begin
        cs_n = 1'b1;
        sclk = 1'b0; // Idle low when deselected
        si = 1'b0;
    end

    // Wait n system clock edges
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask

    // One frame of nb bits, 200 ns per bit
    task automatic xfer(input logic [23:0] tx, input int nb,
                        output logic [23:0] rx);
        rx = 24'h0;
        tick(1);
        cs_n <= 1'b0; // Moves with sclk low
        tick(6);
        for (int i = 0; i < nb; i++) begin
            sclk <= 1'b1;
            si <= (i < 24) ? tx[23 - i] : 1'b0; // MSB first
            tick(4);
            sclk <= 1'b0;
            @(negedge clk);
            rx = {rx[22:0], so_o}; // Sample after the fall
            tick(4);
        end
        cs_n <= 1'b1; // Rises with sclk low
        si <= ~si; // Released line no longer shows last bit
    endtask

    // Clock and data toggling while deselected
    task automatic noise();
        for (int i = 0; i < 4; i++) begin
            sclk <= 1'b1;
            si <= ~si;
            tick(4);
            sclk <= 1'b0;
            tick(4);
        end
    endtask
endmodule

/* test/tb_top.sv */
`timescale 1ns/1ps
`include "swmon_defs.svh"

// ==========================================================
// Testbench top
module tb_top;
    import swmon_pkg::*;

    localparam int K_OE = 0, K_CMD = 1, K_INT = 2, K_SLP = 3, K_SCAN = 4;
    logic clk; // 40 MHz clock
    logic nrst; // Reset, active low
    logic cs_n, sclk, si, so_o, so_oe, int_n_o, int_n_oe;
    logic wake_n_o, wake_n_oe, cmd_valid, sleep_mode;
    logic wetting_on, scan_active, wake_xfer_suspect;
    logic [23:0] cmd_word;
    logic vdd; // Logic supply
    logic therm; // Over-temperature
    logic [7:0] sp; // Programmable inputs
    logic [7:0] sel; // Battery select
    logic [13:0] sg; // Ground inputs
    logic [21:0] int_en; // Alert enables
    logic sleep_req; // Sleep request
    logic ext_int_n; // Other devices on alert wire
    logic ext_wake_n; // Outside pull on wake wire
    int miscompares = 0;
    int n_tests = 0;
    int n_cmd = 0; // Command pulses seen
    // Open-drain wires with pull-ups
    wire int_w = ext_int_n & (int_n_oe ? int_n_o : 1'b1);
    wire wake_w = ext_wake_n & (wake_n_oe ? wake_n_o : 1'b1);
    // Released data line shows the inverse of its last bit
    wire so_w = so_oe ? so_o : ~so_o;

    always #12.5 clk = ~clk;

    switch_monitor_spi_wake_port #(.WET_CYC(20'h14), .SCAN_CYC(20'h4),
        .SCAN_PERIOD(20'h10)) uut (
        .clk(clk), .nrst(nrst), .cs_n(cs_n), .sclk(sclk), .si(si),
        .so_o(so_o), .so_oe(so_oe), .int_n_i(int_w), .int_n_o(int_n_o),
        .int_n_oe(int_n_oe), .wake_n_i(wake_w), .wake_n_o(wake_n_o),
        .wake_n_oe(wake_n_oe), .vdd_present(vdd), .thermal_flag(therm),
        .programmable_switch_inputs(sp), .ground_switch_inputs(sg),
        .sp_battery_sel(sel), .int_enable(int_en), .sleep_req(sleep_req),
        .cmd_word(cmd_word), .cmd_valid(cmd_valid),
        .sleep_mode(sleep_mode), .wetting_on(wetting_on),
        .scan_active(scan_active), .wake_xfer_suspect(wake_xfer_suspect)
    );

    spi_master_model mst (
        .clk(clk), .so_o(so_w), .cs_n(cs_n), .sclk(sclk), .si(si)
    );

    // Count command pulses
    always @(posedge clk) begin
        if (cmd_valid === 1'b1) begin
            n_cmd <= n_cmd + 1;
        end
    end

    // ======================================================
    // Helpers
    task automatic end_of_test();
        $display("Comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [23:0] e,
                       input logic [23:0] g);
        n_tests++;
        if (g !== e) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask

    function automatic logic pick(input int k);
        case (k)
            K_OE: return so_oe;
            K_CMD: return cmd_valid;
            K_INT: return int_n_oe;
            K_SLP: return sleep_mode;
            default: return scan_active;
        endcase
    endfunction

    // Bounded wait for a level, ends after a rising edge
    task automatic wait_val(input int k, input logic v, input string nm);
        int i;
        for (i = 0; i < 80; i++) begin
            @(negedge clk);
            if (pick(k) === v) break;
        end
        chk(nm, {23'h0, v}, {23'h0, pick(k)});
        if (i == 80) begin
            end_of_test();
        end
        @(posedge clk);
    endtask

    // Expected status word, 1 = closed
    function automatic logic [23:0] stat(input logic irq);
        return {irq, therm, ~(sp ^ sel), ~sg};
    endfunction

    task automatic run_frame(input logic [23:0] tx, input logic irq);
        logic [23:0] rx;
        mst.xfer(tx, 24, rx);
        wait_val(K_CMD, 1'b1, "cmd_valid");
        chk("status", stat(irq), rx);
        chk("cmd_word", tx, cmd_word);
        wait_val(K_OE, 1'b0, "so_oe_off");
        mst.tick(8);
    endtask

    task automatic nap();
        sleep_req <= 1'b1;
        @(posedge clk);
        sleep_req <= 1'b0;
        wait_val(K_SLP, 1'b1, "sleep");
        chk("wake_drive", 24'h0, {23'h0, wake_n_oe});
    endtask

    // ======================================================
    // Scenarios
    task automatic t_wet();
        int n;
        n = 0;
        @(negedge clk);
        while (wetting_on === 1'b1 && n < 100) begin
            @(negedge clk);
            n++;
        end
        chk("wet_len", 24'h1, {23'h0, (n >= 19 && n <= 22)});
        @(posedge clk);
    endtask

    task automatic t_frame();
        therm <= 1'b1;
        sp <= 8'h5a;
        sel <= 8'hf0;
        sg <= 14'h2b3c;
        ext_int_n <= 1'b0; // Another device alerting
        mst.tick(8);
        run_frame(24'ha53c96, 1'b0);
        therm <= 1'b0;
        sp <= 8'ha5;
        ext_int_n <= 1'b1;
        mst.tick(8);
        run_frame(24'h5ac369, 1'b0);
    endtask

    task automatic t_count();
        logic [23:0] rx;
        int c0;
        c0 = n_cmd;
        mst.xfer(24'h123456, 23, rx);
        mst.tick(12);
        mst.xfer(24'h654321, 25, rx);
        mst.tick(12);
        mst.noise();
        chk("cmd_count", 24'h0, 24'(n_cmd - c0));
        chk("cmd_kept", 24'h5ac369, cmd_word);
        chk("so_oe_idle", 24'h0, {23'h0, so_oe});
    endtask

    task automatic t_alert();
        logic [23:0] rx;
        int_en <= 22'h3fffff;
        mst.tick(4);
        sg <= sg ^ 14'h0001;
        wait_val(K_INT, 1'b1, "alert_set");
        run_frame(24'h0f0f0f, 1'b1);
        chk("alert_clr", 24'h0, {23'h0, int_n_oe});
        sg <= sg ^ 14'h0002;
        wait_val(K_INT, 1'b1, "alert_set2");
        fork
            mst.xfer(24'h00ff00, 24, rx);
            begin
                mst.tick(60);
                sg <= sg ^ 14'h0004; // Change while selected
            end
        join
        mst.tick(10);
        chk("alert_kept", 24'h1, {23'h0, int_n_oe});
        run_frame(24'h00ff00, 1'b1);
        chk("alert_clr2", 24'h0, {23'h0, int_n_oe});
        int_en <= 22'h000000;
    endtask

    task automatic t_sleep();
        logic [23:0] rx;
        nap();
        mst.xfer(24'h000001, 24, rx);
        wait_val(K_SLP, 1'b0, "cs_wake");
        chk("suspect", 24'h1, {23'h0, wake_xfer_suspect});
        mst.tick(8);
        nap();
        wait_val(K_SCAN, 1'b1, "scan");
        ext_int_n <= 1'b0;
        wait_val(K_SLP, 1'b0, "int_wake");
        chk("wet_wake", 24'h1, {23'h0, wetting_on});
        ext_int_n <= 1'b1;
        nap();
        ext_wake_n <= 1'b0;
        wait_val(K_SLP, 1'b0, "pin_wake");
        ext_wake_n <= 1'b1;
        nap();
        vdd <= 1'b0;
        ext_int_n <= 1'b0;
        mst.tick(10);
        chk("no_int_wake", 24'h1, {23'h0, sleep_mode});
        ext_wake_n <= 1'b0;
        wait_val(K_SLP, 1'b0, "novdd_wake");
        ext_wake_n <= 1'b1;
        ext_int_n <= 1'b1;
        vdd <= 1'b1;
    endtask

    // ======================================================
    // Main sequence and hang guard
    initial begin
        // Idle pin levels, open ground switches and closed programmable switches at time zero
        clk = 1'b0;
        nrst = 1'b0;
        vdd = 1'b1;
        therm = 1'b0;
        sp = 8'h00;
        sel = 8'h00;
        sg = 14'h3fff;
        int_en = 22'h000000;
        sleep_req = 1'b0;
        ext_int_n = 1'b1;
        ext_wake_n = 1'b1;
        repeat (5) @(posedge clk);
        nrst <= 1'b1;
        t_wet();
        t_frame();
        t_count();
        t_alert();
        t_sleep();
        end_of_test();
    end

    initial begin
        repeat (60000) @(posedge clk);
        miscompares++;
        $display("BAD run_length expected done seen hang");
        end_of_test();
    end
endmodule
